// [src/dtpr_pkg.sv]
/*
 * package for the disk task-file parameter register bank: address decode
 * values, control field positions, reset values and carried structs.
 * assumes nothing of its surroundings beyond a single 100 MHz clock.
 */
`default_nettype none
package dtpr_pkg;
	// ------------------------------------------------------------
	// register address on DA2..DA0 (command block, cs0 asserted)
	// ------------------------------------------------------------
	localparam logic [2:0] DTPR_ADDR_ERR_FEAT = 3'h1;
	localparam logic [2:0] DTPR_ADDR_COUNT    = 3'h2;
	localparam logic [2:0] DTPR_ADDR_LOW      = 3'h3;
	localparam logic [2:0] DTPR_ADDR_MID      = 3'h4;
	localparam logic [2:0] DTPR_ADDR_HIGH     = 3'h5;
	localparam logic [2:0] DTPR_ADDR_DEVICE   = 3'h6;
	localparam logic [2:0] DTPR_ADDR_COMMAND  = 3'h7;
	// control block address, cs1 asserted
	localparam logic [2:0] DTPR_ADDR_CONTROL  = 3'h6;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int DTPR_CTL_HOB_BIT    = 7;
	localparam int DTPR_CTL_SOFT_RESET_BIT_BIT   = 2;
	localparam int DTPR_CTL_INTERRUPT_DISABLE_BIT   = 1;
	localparam int DTPR_ERR_ABORT_BIT  = 2;
	localparam int DTPR_DEV_SELECT_BIT = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] DTPR_CTL_RESET   = 8'h00;
	localparam logic [7:0] DTPR_PARAM_RESET = 8'h00;
	localparam logic [7:0] DTPR_DEV_RESET   = 8'h00;
	// default diagnostic code, overridden by the top-level parameter
	localparam logic [7:0] DTPR_DIAG_CODE   = 8'h01;
	localparam logic [7:0] DTPR_ABORT_MASK  = 8'h04;

	// captured command parameters
	typedef struct packed {
		logic [7:0] command;
		logic [7:0] feature;
		logic [7:0] count;
		logic [7:0] low;
		logic [7:0] mid;
		logic [7:0] high;
		logic [7:0] device;
	} dtpr_params_type;

	// live task-file parameter registers
	typedef struct packed {
		logic [7:0] feature;
		logic [7:0] count;
		logic [7:0] low;
		logic [7:0] mid;
		logic [7:0] high;
		logic [7:0] device;
		logic [7:0] control;
		logic [7:0] error;
	} dtpr_file_type;
endpackage
`default_nettype wire

// [src/dtpr_regs.sv]
/*
 * device-side task-file parameter register bank with control register,
 * error register and interrupt line enable.
 * assumes host strobes already synchronised to i_clock and the command
 * engine on the same clock supplies busy, drq, err and command results.
 */
`timescale 1ns/1ps
`default_nettype none
module dtpr_regs
	import dtpr_pkg::*;
#(
	parameter logic       DEVICE_NUMBER = 1'b0,
	parameter logic [7:0] DIAG_CODE     = DTPR_DIAG_CODE
) (
	input  wire logic            i_clock,
	input  wire logic            i_resetn,
	input  wire logic            i_cs0,
	input  wire logic            i_cs1,
	input  wire logic [2:0]      i_addr,
	input  wire logic            i_write,
	input  wire logic            i_read,
	input  wire logic [7:0]      i_wdata,
	input  wire logic            i_busy_flag,
	input  wire logic            i_data_request_flag,
	input  wire logic            i_error_flag,
	input  wire logic            i_irq_condition,
	input  wire logic            i_cmd_aborted,
	input  wire logic [7:0]      i_error_code,
	input  wire logic            i_error_load,
	input  wire logic            i_diag_done,
	output logic [7:0]           o_rdata,
	output logic                 o_rdata_valid,
	output logic                 o_intrq_out,
	output logic                 o_intrq_oe,
	output logic                 o_soft_reset,
	output logic                 o_command_strobe,
	output dtpr_params_type      o_params,
	output logic                 o_high_order_byte_select
);
	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	logic cmd_block;
	logic ctl_block;
	logic wr_cmd_blk;
	logic wr_ctl;
	logic hold_regs;
	logic selected;
	logic ctl_soft_reset_bit_rise;
	logic err_update_ok;

	// both selects high or both low address nothing here; the data port
	// and the status side belong to other blocks, so such cycles are
	// simply ignored rather than decoded
	assign cmd_block  = i_cs0 && !i_cs1;
	assign ctl_block  = i_cs1 && !i_cs0 && (i_addr == DTPR_ADDR_CONTROL);
	assign wr_cmd_blk = i_write && cmd_block;
	assign wr_ctl     = i_write && ctl_block;
	// freeze follows the engine err flag level; it ends as soon as i_error_flag drops
	assign hold_regs  = i_error_flag;

	dtpr_file_type   file_reg;
	dtpr_file_type   file_next;
	dtpr_params_type params_reg;
	dtpr_params_type params_next;
	logic            cmd_strobe_reg;
	logic            cmd_strobe_next;
	logic [7:0]      rdata_reg;
	logic [7:0]      rdata_next;
	logic            rvalid_reg;
	logic            rvalid_next;

	assign ctl_soft_reset_bit_rise = wr_ctl && i_wdata[DTPR_CTL_SOFT_RESET_BIT_BIT]
		&& !file_reg.control[DTPR_CTL_SOFT_RESET_BIT_BIT];

	// engine results may touch the error register only while unfrozen,
	// or in the cycle right after a new command has been accepted
	assign err_update_ok = !hold_regs || cmd_strobe_reg;

	// ------------------------------------------------------------
	// register next state
	// ------------------------------------------------------------
	// one process covers file, params and read data so priorities stay visible
	always_comb begin
		file_next       = file_reg;
		params_next     = params_reg;
		cmd_strobe_next = 1'b0;
		rdata_next      = rdata_reg;
		rvalid_next     = 1'b0;
		// host writes; count through device writes are dropped while frozen, the others land as given
		if (wr_cmd_blk) begin
			file_next.control[DTPR_CTL_HOB_BIT] = 1'b0;
			case (i_addr)
				DTPR_ADDR_ERR_FEAT: file_next.feature = i_wdata;
				DTPR_ADDR_COUNT:    if (!hold_regs) file_next.count = i_wdata;
				DTPR_ADDR_LOW:      if (!hold_regs) file_next.low = i_wdata;
				DTPR_ADDR_MID:      if (!hold_regs) file_next.mid = i_wdata;
				DTPR_ADDR_HIGH:     if (!hold_regs) file_next.high = i_wdata;
				DTPR_ADDR_DEVICE:   if (!hold_regs) file_next.device = i_wdata;
				DTPR_ADDR_COMMAND: begin
					// snapshot before this cycle's writes; command write is alone anyway
					params_next.command = i_wdata;
					params_next.feature = file_reg.feature;
					params_next.count   = file_reg.count;
					params_next.low     = file_reg.low;
					params_next.mid     = file_reg.mid;
					params_next.high    = file_reg.high;
					params_next.device  = file_reg.device;
					cmd_strobe_next     = 1'b1;
				end
				default: ;
			endcase
		end
		// control applies at once; bit 0 and reserved bits are forced to zero
		if (wr_ctl) begin
			file_next.control = {i_wdata[DTPR_CTL_HOB_BIT], 4'h0,
				i_wdata[DTPR_CTL_SOFT_RESET_BIT_BIT], i_wdata[DTPR_CTL_INTERRUPT_DISABLE_BIT], 1'b0};
		end
		// error register: command results unless frozen, diagnostic code wins
		// a stray abort pulse while err is set must not disturb the code
		// the host is about to read, so it is gated like the load
		if (i_error_load && err_update_ok) begin
			file_next.error = i_error_code;
		end
		if (i_cmd_aborted && err_update_ok) begin
			file_next.error = file_next.error | DTPR_ABORT_MASK;
		end
		// reset sources override any result of the same cycle
		if (i_diag_done || ctl_soft_reset_bit_rise) begin
			file_next.error = DIAG_CODE;
		end
		// read data: error register at the shared address
		// the value is a snapshot of the edge the read is taken on, so a
		// write in the same cycle shows only on the next read
		if (i_read && cmd_block) begin
			rvalid_next = 1'b1;
			case (i_addr)
				DTPR_ADDR_ERR_FEAT: rdata_next = file_reg.error;
				DTPR_ADDR_COUNT:    rdata_next = file_reg.count;
				DTPR_ADDR_LOW:      rdata_next = file_reg.low;
				DTPR_ADDR_MID:      rdata_next = file_reg.mid;
				DTPR_ADDR_HIGH:     rdata_next = file_reg.high;
				DTPR_ADDR_DEVICE:   rdata_next = file_reg.device;
				default: begin
					rdata_next  = 8'h00;
					rvalid_next = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// hardware reset loads the diagnostic code as the power-on result
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			file_reg       <= '{
				feature: DTPR_PARAM_RESET,
				count:   DTPR_PARAM_RESET,
				low:     DTPR_PARAM_RESET,
				mid:     DTPR_PARAM_RESET,
				high:    DTPR_PARAM_RESET,
				device:  DTPR_DEV_RESET,
				control: DTPR_CTL_RESET,
				error:   DIAG_CODE
			};
			params_reg     <= '0;
			cmd_strobe_reg <= 1'b0;
			rdata_reg      <= 8'h00;
			rvalid_reg     <= 1'b0;
		end else begin
			file_reg       <= file_next;
			params_reg     <= params_next;
			cmd_strobe_reg <= cmd_strobe_next;
			rdata_reg      <= rdata_next;
			rvalid_reg     <= rvalid_next;
		end
	end

	// ------------------------------------------------------------
	// interrupt line and outputs
	// ------------------------------------------------------------
	// the enable is combinational so a control write takes effect in the
	// very next cycle; the pad driver and its resolution live outside
	// select follows the device register as written, not the captured copy
	assign selected = (file_reg.device[DTPR_DEV_SELECT_BIT] == DEVICE_NUMBER);
	// released line has the enable low; the wire resolves outside
	assign o_intrq_oe  = selected && !file_reg.control[DTPR_CTL_INTERRUPT_DISABLE_BIT];
	assign o_intrq_out = o_intrq_oe && i_irq_condition;

	// soft_reset_bit level kept as written; engine runs reset while it is one, in any power state
	assign o_soft_reset             = file_reg.control[DTPR_CTL_SOFT_RESET_BIT_BIT];
	assign o_high_order_byte_select = file_reg.control[DTPR_CTL_HOB_BIT];
	assign o_command_strobe         = cmd_strobe_reg;
	assign o_params                 = params_reg;
	assign o_rdata                  = rdata_reg;
	assign o_rdata_valid            = rvalid_reg;
endmodule // dtpr_regs
`default_nettype wire

// [test/dtpr_host_line.sv]
/* host side of the interrupt wire for the task-file register bank.
   assumes the host holds a pull-down on the line while no device drives it. */
`timescale 1ns/1ps
`default_nettype none
module dtpr_host_line (
	input  wire logic i_oe,
	input  wire logic i_out,
	output logic      o_line
);
	// released line falls to the pull-down level, never the last value
	assign o_line = i_oe ? i_out : 1'b0;
endmodule // dtpr_host_line
`default_nettype wire

// [test/dtpr_regs_checker.sv]
/* concurrent checks on the task-file register bank ports.
   assumes one clock domain and a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module dtpr_regs_checker
	import dtpr_pkg::*;
(
	input wire logic            i_clock,
	input wire logic            i_resetn,
	input wire logic            i_cs0,
	input wire logic            i_cs1,
	input wire logic            i_write,
	input wire logic            i_read,
	input wire logic            i_irq_condition,
	input wire logic            o_rdata_valid,
	input wire logic            o_intrq_out,
	input wire logic            o_intrq_oe,
	input wire logic            o_soft_reset,
	input wire logic            o_command_strobe,
	input wire logic            o_high_order_byte_select,
	input wire logic [2:0]      i_addr,
	input wire logic [7:0]      i_wdata,
	input wire dtpr_params_type o_params
);
	// -------------------------------------------------------------
	// write decode and properties
	// -------------------------------------------------------------
	wire logic cmdw = i_write && i_cs0 && !i_cs1;
	wire logic ctlw = i_write && i_cs1 && !i_cs0 && i_addr == DTPR_ADDR_CONTROL;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	a_hob_write_clear: assert property (cmdw |=> !o_high_order_byte_select)
		else $error("hob not cleared by write");
	a_ctl_applied: assert property (ctlw |=> o_high_order_byte_select == $past(i_wdata[7])
		&& o_soft_reset == $past(i_wdata[2])) else $error("control not applied");
	a_interrupt_disable_release: assert property (ctlw && i_wdata[1] |=> !o_intrq_oe)
		else $error("line driven with interrupt_disable set");
	a_line_released: assert property (!o_intrq_oe |-> !o_intrq_out)
		else $error("released line not low");
	a_line_follows: assert property (o_intrq_oe |-> o_intrq_out == i_irq_condition)
		else $error("line not following condition");
	a_read_answer: assert property (i_read && i_cs0 && !i_cs1 && i_addr inside {[1:5]}
		|=> o_rdata_valid) else $error("read not answered");
	a_read_refused: assert property (i_read && i_addr == 3'h0 |=> !o_rdata_valid)
		else $error("unmapped read answered");
	a_cmd_capture: assert property (cmdw && i_addr == DTPR_ADDR_COMMAND |=> o_command_strobe
		&& o_params.command == $past(i_wdata)) else $error("command not captured");
	c_command: cover property (o_command_strobe);
	c_soft_reset: cover property ($rose(o_soft_reset));
	c_line_high: cover property (o_intrq_oe && o_intrq_out);
endmodule // dtpr_regs_checker
`default_nettype wire

// [test/dtpr_regs_bench.sv]
/* self-checking bench for the task-file register bank, host write/read tasks.
   assumes the design answers reads one cycle after the taken edge. */
`timescale 1ns/1ps
`default_nettype none
module dtpr_regs_bench
	import dtpr_pkg::*;
;
	logic i_clock = 0, i_resetn = 0, i_cs0 = 0, i_cs1 = 0, i_write = 0, i_read = 0;
	logic i_error_flag = 0, i_irq_condition = 0, i_cmd_aborted = 0, i_error_load = 0;
	logic i_diag_done = 0, o_rdata_valid, o_intrq_out, o_intrq_oe, o_soft_reset;
	logic o_command_strobe, o_high_order_byte_select, intrq_line;
	logic [2:0] i_addr = 0;
	logic [7:0] i_wdata = 0, i_error_code = 8'h5A, o_rdata;
	dtpr_params_type o_params;
	int fail_count = 0, samples_checked = 0, cycles = 0;
	// -------------------------------------------------------------
	// design, host line and access tasks
	// -------------------------------------------------------------
	dtpr_regs uut (
		.i_clock                  (i_clock),
		.i_resetn                 (i_resetn),
		.i_cs0                    (i_cs0),
		.i_cs1                    (i_cs1),
		.i_addr                   (i_addr),
		.i_write                  (i_write),
		.i_read                   (i_read),
		.i_wdata                  (i_wdata),
		.i_busy_flag              (1'b0),
		.i_data_request_flag      (1'b0),
		.i_error_flag             (i_error_flag),
		.i_irq_condition          (i_irq_condition),
		.i_cmd_aborted            (i_cmd_aborted),
		.i_error_code             (i_error_code),
		.i_error_load             (i_error_load),
		.i_diag_done              (i_diag_done),
		.o_rdata                  (o_rdata),
		.o_rdata_valid            (o_rdata_valid),
		.o_intrq_out              (o_intrq_out),
		.o_intrq_oe               (o_intrq_oe),
		.o_soft_reset             (o_soft_reset),
		.o_command_strobe         (o_command_strobe),
		.o_params                 (o_params),
		.o_high_order_byte_select (o_high_order_byte_select)
	);
	dtpr_host_line u_line (.i_oe(o_intrq_oe), .i_out(o_intrq_out), .o_line(intrq_line));
	always #5 i_clock = ~i_clock;
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// each access drives for one edge, then releases one edge later
	task automatic wr(input logic cs1, input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clock) #1 {i_cs0, i_cs1, i_addr, i_wdata, i_write} = {!cs1, cs1, a, d, 1'b1};
		@(posedge i_clock) #1 i_write = 0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [8:0] exp);
		@(posedge i_clock) #1 {i_cs0, i_cs1, i_addr, i_read} = {1'b1, 1'b0, a, 1'b1};
		@(posedge i_clock) #1 i_read = 0;
		chk(exp[8] ? {o_rdata_valid, o_rdata} : {o_rdata_valid, 8'h00}, exp, "read");
	endtask
	// bit 2 diag done, bit 1 command aborted, bit 0 error load
	task automatic hit(input logic [2:0] which);
		@(posedge i_clock) #1 {i_diag_done, i_cmd_aborted, i_error_load} = which;
		@(posedge i_clock) #1 {i_diag_done, i_cmd_aborted, i_error_load} = 3'h0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hang guard, the tests need about 80 cycles
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge i_clock);
		#1 i_resetn = 1;
		rd(3'h1, 9'h101);
		chk(o_intrq_oe, 1'b1, "intrq enable");
		rd(3'h0, 9'h000);
		for (int k = 2; k <= 5; k++) wr(1'b0, k[2:0], 8'h10 + k[7:0]);
		wr(1'b0, 3'h1, 8'hA5);
		for (int k = 2; k <= 5; k++) rd(k[2:0], {1'b1, 8'h10 + k[7:0]});
		rd(3'h1, 9'h101);
		$display("test register file done");
		wr(1'b0, 3'h7, 8'hEC);
		chk(o_command_strobe, 1'b1, "command strobe");
		chk(o_params, {8'hEC, 8'hA5, 8'h12, 8'h13, 8'h14, 8'h15, 8'h00}, "params");
		wr(1'b1, 3'h6, 8'h80);
		chk(o_high_order_byte_select, 1'b1, "hob set");
		wr(1'b0, 3'h3, 8'h33);
		chk(o_high_order_byte_select, 1'b0, "hob cleared");
		$display("test command and hob done");
		i_error_flag = 1;
		wr(1'b0, 3'h3, 8'h77);
		rd(3'h3, 9'h133);
		hit(3'h1);
		hit(3'h2);
		rd(3'h1, 9'h101);
		i_error_flag = 0;
		hit(3'h1);
		rd(3'h1, 9'h15A);
		hit(3'h2);
		rd(3'h1, 9'h15E);
		$display("test error freeze done");
		i_irq_condition = 1;
		wr(1'b1, 3'h6, 8'h02);
		chk({o_intrq_oe, intrq_line}, 2'b00, "line disabled");
		wr(1'b1, 3'h6, 8'h00);
		chk({o_intrq_oe, intrq_line}, 2'b11, "line driven");
		wr(1'b0, 3'h6, 8'h10);
		chk({o_intrq_oe, intrq_line}, 2'b00, "other device");
		wr(1'b0, 3'h6, 8'h00);
		$display("test interrupt line done");
		wr(1'b1, 3'h6, 8'h04);
		chk(o_soft_reset, 1'b1, "soft reset");
		rd(3'h1, 9'h101);
		wr(1'b1, 3'h6, 8'h00);
		hit(3'h1);
		hit(3'h4);
		rd(3'h1, 9'h101);
		$display("test resets done");
		summarize();
	end
endmodule // dtpr_regs_bench
bind dtpr_regs dtpr_regs_checker u_chk (
	.i_clock                  (i_clock),
	.i_resetn                 (i_resetn),
	.i_cs0                    (i_cs0),
	.i_cs1                    (i_cs1),
	.i_write                  (i_write),
	.i_read                   (i_read),
	.i_irq_condition          (i_irq_condition),
	.o_rdata_valid            (o_rdata_valid),
	.o_intrq_out              (o_intrq_out),
	.o_intrq_oe               (o_intrq_oe),
	.o_soft_reset             (o_soft_reset),
	.o_command_strobe         (o_command_strobe),
	.o_high_order_byte_select (o_high_order_byte_select),
	.i_addr                   (i_addr),
	.i_wdata                  (i_wdata),
	.o_params                 (o_params)
);
`default_nettype wire
